/* sar_comparator_model.sv */
// Behavioural comparator standing in for the analog front end of the converter.
`default_nettype none
module sar_comparator_model (
	input  wire logic [15:0] inputCode,
	input  wire logic [15:0] trialCode,
	output logic             compHigh
);
	timeunit 1ns;
	timeprecision 1ps;
	// Keeping a bit on equality makes the final word equal the held input exactly.
	assign compHigh = (inputCode >= trialCode);
endmodule
`default_nettype wire

/* sar_conv_pkg.sv */
// Constants, pin indices and state encoding shared by the conversion control design.
// Overview of operation
// - A low on convert start ends acquisition and begins a conversion.
// - Conversions are launched only through the convert start input.
// - A running conversion always completes; convert start and sleep are ignored.
// - Convert start works regardless of chip select and read enable.
// - Convert start held low at busy fall times acquisition, then reconverts.
// - Self-retriggered conversions may run slightly faster than rated throughput.
// - Chip select OR read enable high floats the data bus outputs; busy and the status outputs stay driven.
// - Serial output shares the parallel data pins, chosen by interface select.
// - Output coding select picks straight binary or two's complement.
// - Two's complement equals straight binary with its top bit inverted.
// - Both power-downs low enable internal reference and buffer gain two.
// - Reference power-down high alone gives external reference, buffer gain one.
// - Both power-downs high disable internal reference and internal buffer.
// - Sleep never disables the internal reference or buffer.
// - Low power after every conversion; digital interface stays active.
// - After the last bit decision the result is stored and busy drops.
`default_nettype none
package sar_conv_pkg;
	// Core clock and derived timing.
	localparam int CLK_PERIOD_NS     = 8;
	localparam int BIT_TIME_NS       = 96;
	localparam int BIT_CYCLES        = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int THROUGHPUT_KSPS   = 500;
	localparam int SAMPLE_PERIOD_NS  = 1000000 / THROUGHPUT_KSPS;
	localparam int SAMPLE_CYCLES     = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int RESULT_BITS       = 16;
	localparam int CONV_CYCLES       = RESULT_BITS * BIT_CYCLES;
	localparam int AUTO_MARGIN       = 4;
	localparam int AUTO_ACQ_CYCLES   = SAMPLE_CYCLES - CONV_CYCLES - AUTO_MARGIN;
	localparam int CNT_W             = 8;
	localparam int BIDX_W            = 4;
	// Positions of the pin inputs inside the synchroniser vector.
	localparam int PIN_CNV           = 0;
	localparam int PIN_SLEEP         = 1;
	localparam int PIN_REFPD         = 2;
	localparam int PIN_BUFPD         = 3;
	localparam int PIN_CODING        = 4;
	localparam int PIN_CS            = 5;
	localparam int PIN_RD            = 6;
	localparam int PIN_SER           = 7;
	localparam int PIN_SCLK          = 8;
	localparam int PIN_COUNT         = 9;
	// Values after reset; active-low pins idle high.
	localparam logic [8:0]  RESET_PINS   = 9'h061;
	localparam logic [15:0] RESET_RESULT = 16'h0000;
	typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_ACQUIRE} conv_state_t;
endpackage
`default_nettype wire

/* sar_conversion_control.sv */
// Conversion sequencer, reference control and output bus driver of the converter.
`default_nettype none
module sar_conversion_control #(
	parameter int RES_BITS = 16
) (
	input  wire logic                core_clk,
	input  wire logic                resetn,
	input  wire logic                convertStartN,
	input  wire logic                sleepRequest,
	input  wire logic                refPowerdown,
	input  wire logic                bufferPowerdown,
	input  wire logic                outputCodingSelect,
	input  wire logic                chipSelectN,
	input  wire logic                readEnableN,
	input  wire logic                serialSelect,
	input  wire logic                serialClk,
	input  wire logic                compHigh,
	output logic                     busy,
	output logic                     lowPower,
	output logic                     sleepActive,
	output logic                     refEnable,
	output logic                     bufferEnable,
	output logic                     bufferGainTwo,
	output logic     [RES_BITS-1:0]  trialCode,
	output logic     [RES_BITS-1:0]  dataOut,
	output logic                     dataOe
);
	typedef struct packed {
		sar_conv_pkg::conv_state_t          st;
		logic [sar_conv_pkg::PIN_COUNT-1:0] syncA;
		logic [sar_conv_pkg::PIN_COUNT-1:0] syncB;
		logic                               cnvPrev;
		logic                               sclkPrev;
		logic                               oePrev;
		logic [sar_conv_pkg::BIDX_W-1:0]    bitIdx;
		logic [sar_conv_pkg::CNT_W-1:0]     cnt;
		logic [RES_BITS-1:0]                sar;
		logic                               busy;
		logic [RES_BITS-1:0]                shift;
		logic [RES_BITS-1:0]                dataOut;
		logic                               refEn;
		logic                               bufEn;
		logic                               gainTwo;
	} ctl_t;

	ctl_t                ctl_ff;
	ctl_t                nxt_ctl;
	logic                storeWrite;
	logic [RES_BITS-1:0] storeData;
	logic [RES_BITS-1:0] storeRead;
	logic                cnvLow;
	logic                sleepLvl;
	logic                startEdge;
	logic                bitDone;
	logic [RES_BITS-1:0] decided;

	// Coding of a straight binary word; two's complement flips only the top bit.
	function automatic logic [RES_BITS-1:0] codeResult(input logic [RES_BITS-1:0] raw,
			input logic straightBin);
		codeResult = {raw[RES_BITS-1] ^ ~straightBin, raw[RES_BITS-2:0]};
	endfunction

	// One-hot weight of the bit under decision.
	function automatic logic [RES_BITS-1:0] bitWeight(input logic [sar_conv_pkg::BIDX_W-1:0] idx);
		bitWeight = '0;
		bitWeight[idx] = 1'b1;
	endfunction

	// Levels taken only from the second synchroniser stage.
	assign cnvLow    = ~ctl_ff.syncB[sar_conv_pkg::PIN_CNV];
	assign sleepLvl  = ctl_ff.syncB[sar_conv_pkg::PIN_SLEEP];
	assign startEdge = cnvLow & ctl_ff.cnvPrev;
	assign bitDone   = (ctl_ff.cnt == '0);
	assign decided   = compHigh ? (ctl_ff.sar | bitWeight(ctl_ff.bitIdx)) : ctl_ff.sar;

	// Sequencer, pin synchronisers, reference decode and output shaping.
	always_comb begin
		nxt_ctl          = ctl_ff;
		storeWrite       = 1'b0;
		storeData        = decided;
		nxt_ctl.syncA    = {serialClk, serialSelect, readEnableN, chipSelectN,
			outputCodingSelect, bufferPowerdown, refPowerdown, sleepRequest, convertStartN};
		nxt_ctl.syncB    = ctl_ff.syncA;
		nxt_ctl.cnvPrev  = ~cnvLow;
		nxt_ctl.sclkPrev = ctl_ff.syncB[sar_conv_pkg::PIN_SCLK];
		nxt_ctl.oePrev   = dataOe;
		// Chip select and read enable are not consulted here at all.
		unique case (ctl_ff.st)
			sar_conv_pkg::ST_IDLE: begin
				// Sleep holds the part idle, but only in idle; the automatic acquisition ignores it.
				if (startEdge && !sleepLvl) begin
					nxt_ctl.st     = sar_conv_pkg::ST_CONVERT;
					nxt_ctl.busy   = 1'b1;
					nxt_ctl.sar    = '0;
					nxt_ctl.bitIdx = sar_conv_pkg::BIDX_W'(RES_BITS - 1);
					nxt_ctl.cnt    = sar_conv_pkg::CNT_W'(sar_conv_pkg::BIT_CYCLES - 1);
				end
			end
			sar_conv_pkg::ST_CONVERT: begin
				// Convert start and sleep are deliberately ignored until the end.
				nxt_ctl.cnt = ctl_ff.cnt - 1'b1;
				if (bitDone) begin
					nxt_ctl.sar = decided;
					nxt_ctl.cnt = sar_conv_pkg::CNT_W'(sar_conv_pkg::BIT_CYCLES - 1);
					nxt_ctl.bitIdx = ctl_ff.bitIdx - 1'b1;
					if (ctl_ff.bitIdx == '0) begin
						storeWrite   = 1'b1;
						nxt_ctl.busy = 1'b0;
						if (cnvLow) begin
							nxt_ctl.st  = sar_conv_pkg::ST_ACQUIRE;
							nxt_ctl.cnt = sar_conv_pkg::CNT_W'(sar_conv_pkg::AUTO_ACQ_CYCLES - 1);
						end else begin
							nxt_ctl.st = sar_conv_pkg::ST_IDLE;
						end
					end
				end
			end
			sar_conv_pkg::ST_ACQUIRE: begin
				// The auto acquisition is four cycles shorter than the rated period leaves after a conversion.
				nxt_ctl.cnt = ctl_ff.cnt - 1'b1;
				if (!cnvLow) begin
					nxt_ctl.st = sar_conv_pkg::ST_IDLE;
				end else if (bitDone) begin
					nxt_ctl.st     = sar_conv_pkg::ST_CONVERT;
					nxt_ctl.busy   = 1'b1;
					nxt_ctl.sar    = '0;
					nxt_ctl.bitIdx = sar_conv_pkg::BIDX_W'(RES_BITS - 1);
					nxt_ctl.cnt    = sar_conv_pkg::CNT_W'(sar_conv_pkg::BIT_CYCLES - 1);
				end
			end
			default: begin
				nxt_ctl.st = sar_conv_pkg::ST_IDLE;
			end
		endcase
		// Reference and buffer follow their own pins only, never sleep.
		nxt_ctl.refEn   = ~ctl_ff.syncB[sar_conv_pkg::PIN_REFPD];
		nxt_ctl.bufEn   = ~ctl_ff.syncB[sar_conv_pkg::PIN_BUFPD];
		nxt_ctl.gainTwo = ~ctl_ff.syncB[sar_conv_pkg::PIN_REFPD]
			& ~ctl_ff.syncB[sar_conv_pkg::PIN_BUFPD];
		// Serial word loads as the outputs turn on and shifts on each clock rise.
		if (dataOe && !ctl_ff.oePrev) begin
			nxt_ctl.shift = codeResult(storeRead, ctl_ff.syncB[sar_conv_pkg::PIN_CODING]);
		end else if (dataOe && ctl_ff.syncB[sar_conv_pkg::PIN_SCLK] && !ctl_ff.sclkPrev) begin
			nxt_ctl.shift = {ctl_ff.shift[RES_BITS-2:0], 1'b0};
		end
		// Serial data takes bit zero of the shared bus; the other pins read low.
		if (ctl_ff.syncB[sar_conv_pkg::PIN_SER]) begin
			nxt_ctl.dataOut = {{(RES_BITS-1){1'b0}}, ctl_ff.shift[RES_BITS-1]};
		end else begin
			nxt_ctl.dataOut = codeResult(storeRead,
				ctl_ff.syncB[sar_conv_pkg::PIN_CODING]);
		end
	end

	// State register; pins reset to their idle levels so no edge is invented.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_ff         <= '0;
			ctl_ff.st      <= sar_conv_pkg::ST_IDLE;
			ctl_ff.syncA   <= sar_conv_pkg::RESET_PINS;
			ctl_ff.syncB   <= sar_conv_pkg::RESET_PINS;
			ctl_ff.cnvPrev <= 1'b1;
			ctl_ff.sar     <= sar_conv_pkg::RESET_RESULT;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	sar_result_store #(
		.WIDTH     (RES_BITS)
	) u_store (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.writeEn   (storeWrite),
		.writeData (storeData),
		.readData  (storeRead)
	);

	// Either select high floats the bus; the enable is a combined handshake term.
	assign dataOe = ~(ctl_ff.syncB[sar_conv_pkg::PIN_CS]
		| ctl_ff.syncB[sar_conv_pkg::PIN_RD]);
	assign busy          = ctl_ff.busy;
	assign lowPower      = ~ctl_ff.busy;
	assign sleepActive   = sleepLvl & (ctl_ff.st == sar_conv_pkg::ST_IDLE);
	assign refEnable     = ctl_ff.refEn;
	assign bufferEnable  = ctl_ff.bufEn;
	assign bufferGainTwo = ctl_ff.gainTwo;
	assign trialCode     = ctl_ff.busy ? (ctl_ff.sar | bitWeight(ctl_ff.bitIdx)) : ctl_ff.sar;
	assign dataOut       = ctl_ff.dataOut;

	// Helper counter of busy cycles, read only by the checks below.
	localparam int CONV_LEN = sar_conv_pkg::CONV_CYCLES;
	localparam int AUTO_MAX = 60;
	logic [8:0] busyLen_ff;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busyLen_ff <= '0;
		end else begin
			busyLen_ff <= busy ? busyLen_ff + 1'b1 : '0;
		end
	end

	// Helper counter of idle cycles, read only by the automatic period check below.
	logic [8:0] idleLen_ff;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			idleLen_ff <= '0;
		end else begin
			idleLen_ff <= busy ? '0 : idleLen_ff + 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_START_BUSY: assert property ((ctl_ff.st == sar_conv_pkg::ST_IDLE) && startEdge
		&& !sleepLvl |=> busy && !lowPower)
		else $error("Convert start edge did not raise busy.");
	AST_NO_ABORT: assert property (busy && busyLen_ff < 9'(CONV_LEN - 1) |=> busy)
		else $error("Conversion ended early.");
	AST_BUSY_LEN: assert property ($fell(busy) |-> busyLen_ff == 9'(CONV_LEN))
		else $error("Busy width is not one full conversion.");
	AST_AUTO_RESTART: assert property ($fell(busy) && cnvLow |->
		##[1:AUTO_MAX] (busy || !cnvLow))
		else $error("Held convert start did not retrigger.");
	AST_FLOAT: assert property (chipSelectN [*3] |-> !dataOe)
		else $error("Bus driven while chip select high.");
	AST_DRIVE: assert property ((!chipSelectN && !readEnableN) [*3] |-> dataOe)
		else $error("Bus not driven with both selects low.");
	AST_CODING: assert property (!ctl_ff.syncB[sar_conv_pkg::PIN_SER] ##1 1 |->
		dataOut[RES_BITS-1] == ($past(storeRead[RES_BITS-1])
		^ ~$past(ctl_ff.syncB[sar_conv_pkg::PIN_CODING])))
		else $error("Output coding top bit wrong.");
	AST_REF_MODES: assert property (bufferGainTwo |-> refEnable && bufferEnable)
		else $error("Gain two without internal reference and buffer.");
	AST_LOW_POWER: assert property ($fell(busy) |-> lowPower)
		else $error("Low power not entered after conversion.");

	// A steady pair of low power-down pins must give the internal reference at gain two.
	AST_REF_INTERNAL: assert property ((!refPowerdown && !bufferPowerdown) [*4] |->
		refEnable && bufferEnable && bufferGainTwo)
		else $error("Internal reference mode not decoded.");
	// An external reference through the buffer runs the buffer at unity gain.
	AST_REF_EXTERNAL: assert property ((refPowerdown && !bufferPowerdown) [*4] |->
		!refEnable && bufferEnable && !bufferGainTwo)
		else $error("External reference mode not decoded.");
	// With both pins high nothing internal may stay powered.
	AST_REF_NONE: assert property ((refPowerdown && bufferPowerdown) [*4] |->
		!refEnable && !bufferEnable)
		else $error("Reference or buffer left on with both power-downs high.");
	// Sleep must not take the reference down; only its own pins may.
	AST_SLEEP_REF: assert property ((sleepRequest && !refPowerdown
		&& !bufferPowerdown) [*4] |-> refEnable && bufferEnable)
		else $error("Sleep changed the reference or buffer state.");
	// Idle without a start edge must stay idle; nothing else launches a conversion.
	AST_ONLY_START: assert property ((ctl_ff.st == sar_conv_pkg::ST_IDLE)
		&& !startEdge |=> !busy)
		else $error("Conversion began without a start edge.");
	// Every new conversion starts from the top bit alone.
	AST_TRIAL_TOP: assert property ($rose(busy) |->
		trialCode == {1'b1, {(RES_BITS-1){1'b0}}})
		else $error("Conversion did not start at the top bit.");
	// The result is written in the same cycle that busy drops.
	AST_STORE_AT_END: assert property ($fell(busy) |-> $past(storeWrite))
		else $error("Busy dropped without storing a result.");
	// In the automatic acquisition busy is low and power is reduced.
	AST_ACQ_LOW_POWER: assert property ((ctl_ff.st == sar_conv_pkg::ST_ACQUIRE)
		|-> lowPower && !busy)
		else $error("Acquisition ran with busy high.");
	// Releasing convert start during acquisition stops the automatic loop.
	AST_ACQ_EXIT: assert property ((ctl_ff.st == sar_conv_pkg::ST_ACQUIRE)
		&& !cnvLow |=> (ctl_ff.st == sar_conv_pkg::ST_IDLE) && !busy)
		else $error("Automatic loop did not stop.");
	// An automatic restart follows exactly the planned acquisition time.
	AST_AUTO_PERIOD: assert property ($rose(busy)
		&& ($past(ctl_ff.st) == sar_conv_pkg::ST_ACQUIRE)
		|-> idleLen_ff == 9'(sar_conv_pkg::AUTO_ACQ_CYCLES))
		else $error("Automatic acquisition time is off.");
	// Read enable alone must float the bus as well.
	AST_FLOAT_RD: assert property (readEnableN [*3] |-> !dataOe)
		else $error("Bus driven while read enable high.");
	// Serial mode leaves every data pin but the shared bit low.
	AST_SERIAL_PINS: assert property (ctl_ff.syncB[sar_conv_pkg::PIN_SER] |=>
		dataOut[RES_BITS-1:1] == '0)
		else $error("Serial mode drove the parallel bits.");
	// Straight binary passes the stored word through unchanged.
	AST_CODE_BINARY: assert property (ctl_ff.syncB[sar_conv_pkg::PIN_CODING]
		&& !ctl_ff.syncB[sar_conv_pkg::PIN_SER] |=> dataOut == $past(storeRead))
		else $error("Straight binary word altered.");
	// Two's complement differs from straight binary in the top bit only.
	AST_CODE_TWOS: assert property (!ctl_ff.syncB[sar_conv_pkg::PIN_CODING]
		&& !ctl_ff.syncB[sar_conv_pkg::PIN_SER]
		|=> dataOut == ($past(storeRead) ^ {1'b1, {(RES_BITS-1){1'b0}}}))
		else $error("Two's complement word wrong.");

	COV_SINGLE: cover property ($rose(busy) ##[1:300] $fell(busy));
	COV_AUTO: cover property ($fell(busy) && cnvLow ##[1:AUTO_MAX] $rose(busy));
	COV_READ: cover property (dataOe && !ctl_ff.syncB[sar_conv_pkg::PIN_SER]);
	COV_SERIAL: cover property (dataOe && ctl_ff.syncB[sar_conv_pkg::PIN_SER]);
	COV_AUTO_EXIT: cover property ((ctl_ff.st == sar_conv_pkg::ST_ACQUIRE) && !cnvLow);
endmodule
`default_nettype wire

/* sar_result_store.sv */
// One-word result store with registered read data.
`default_nettype none
module sar_result_store #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             writeEn,
	input  wire logic [WIDTH-1:0] writeData,
	output logic      [WIDTH-1:0] readData
);
	logic [WIDTH-1:0] word_ff;

	// The word is written once per conversion; read data lags one cycle.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			word_ff  <= '0;
			readData <= '0;
		end else begin
			if (writeEn) begin
				word_ff <= writeData;
			end
			readData <= word_ff;
		end
	end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for conversion sequencing, reference decode and the output bus.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CONVC = sar_conv_pkg::CONV_CYCLES;
	logic        core_clk, resetn, convertStartN, sleepRequest, refPowerdown;
	logic        bufferPowerdown, outputCodingSelect, chipSelectN, readEnableN;
	logic        serialSelect, serialClk, compHigh, busy, lowPower, sleepActive;
	logic        refEnable, bufferEnable, bufferGainTwo, dataOe;
	logic [15:0] trialCode, dataOut, analog, res;
	logic [1:0]  pdTab [3] = '{2'b00, 2'b10, 2'b11};
	logic [2:0]  enTab [3] = '{3'b111, 3'b010, 3'b000};
	int          failures = 0, total_checks = 0, cycles = 0, w, w2;

	sar_conversion_control u_sar_conversion_control (.core_clk(core_clk), .resetn(resetn),
		.convertStartN(convertStartN), .sleepRequest(sleepRequest),
		.refPowerdown(refPowerdown), .bufferPowerdown(bufferPowerdown),
		.outputCodingSelect(outputCodingSelect), .chipSelectN(chipSelectN),
		.readEnableN(readEnableN), .serialSelect(serialSelect), .serialClk(serialClk),
		.compHigh(compHigh), .busy(busy), .lowPower(lowPower), .sleepActive(sleepActive),
		.refEnable(refEnable), .bufferEnable(bufferEnable), .bufferGainTwo(bufferGainTwo),
		.trialCode(trialCode), .dataOut(dataOut), .dataOe(dataOe));
	sar_comparator_model u_sar_comparator_model (.inputCode(analog), .trialCode(trialCode),
		.compHigh(compHigh));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Hang guard; the whole run needs well under this many cycles.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			stop_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic [15:0] exp_code(input logic [15:0] c, input logic sb);
		return sb ? c : (c ^ 16'h8000);
	endfunction

	task automatic ticks(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	// Bounded wait at falling edges until busy reaches the wanted level.
	task automatic wait_busy(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (busy !== lvl && cnt < lim) begin
			@(negedge core_clk);
			cnt++;
		end
	endtask

	// One conversion with start, restart and sleep noise inside it, then a read.
	task automatic convert(input logic [15:0] code, input logic sb);
		analog = code;
		outputCodingSelect = sb;
		convertStartN = 1'b0;
		wait_busy(1'b1, 8, w);
		check(16'(busy), 16'h1);
		check(trialCode, 16'h8000);
		convertStartN = 1'b1;
		sleepRequest = 1'b1;
		chipSelectN = 1'($urandom);
		readEnableN = 1'($urandom);
		ticks(40);
		sleepRequest = 1'b0;
		convertStartN = 1'b0;
		ticks(3);
		check(16'(lowPower), 16'h0);
		convertStartN = 1'b1;
		wait_busy(1'b0, 300, w);
		check(16'(w + 43), 16'(CONVC));
		chipSelectN = 1'b0;
		readEnableN = 1'b0;
		ticks(4);
		check(16'(lowPower), 16'h1);
		check(trialCode, code);
		check(16'(dataOe), 16'h1);
		check(dataOut, exp_code(code, sb));
		readEnableN = 1'b1;
		ticks(3);
		check(16'(dataOe), 16'h0);
		readEnableN = 1'b0;
		chipSelectN = 1'b1;
		ticks(3);
		check(16'(dataOe), 16'h0);
		readEnableN = 1'b1;
	endtask

	initial begin
		{convertStartN, chipSelectN, readEnableN, outputCodingSelect} = 4'hF;
		{sleepRequest, refPowerdown, bufferPowerdown, serialSelect, serialClk} = 5'h00;
		analog = 16'h0000;
		resetn = 1'b0;
		void'($urandom(10));
		ticks(6);
		check(16'({busy, lowPower, dataOe}), 16'h0002);
		resetn = 1'b1;
		ticks(2);
		// Reference decode, with sleep raised in some rows to show it has no say.
		for (int i = 0; i < 3; i++) begin
			{refPowerdown, bufferPowerdown} = pdTab[i];
			sleepRequest = (i != 1);
			ticks(5);
			check(16'({refEnable, bufferEnable, bufferGainTwo}), 16'(enTab[i]));
			check(16'(sleepActive), 16'(i != 1));
		end
		sleepRequest = 1'b0;
		ticks(3);
		convert(16'h0000, 1'b1);
		convert(16'hFFFF, 1'b0);
		convert(16'h8000, 1'b0);
		convert(16'h7FFF, 1'b1);
		repeat (4) convert(16'($urandom), 1'($urandom));
		// Free-running: convert start held low keeps conversions coming.
		analog = 16'($urandom);
		convertStartN = 1'b0;
		wait_busy(1'b1, 8, w);
		wait_busy(1'b0, 300, w);
		wait_busy(1'b1, 300, w2);
		check(16'(busy), 16'h1);
		check(16'(w + w2 <= sar_conv_pkg::SAMPLE_CYCLES), 16'h1);
		check(16'(w), 16'(CONVC));
		check(16'(w2), 16'(sar_conv_pkg::AUTO_ACQ_CYCLES));
		convertStartN = 1'b1;
		wait_busy(1'b0, 300, w);
		ticks(4);
		// Serial read of a fresh result, clock held low until the frame opens, then pulsed inside it.
		res = 16'($urandom);
		convert(res, 1'b1);
		serialSelect = 1'b1;
		chipSelectN = 1'b0;
		readEnableN = 1'b0;
		ticks(4);
		for (int b = 15; b >= 0; b--) begin
			check(16'(dataOut[0]), 16'(res[b]));
			serialClk = 1'b1;
			ticks(3);
			serialClk = 1'b0;
			ticks(3);
		end
		stop_test();
	end
endmodule
`default_nettype wire
